// ---- verilog/sslsd_pkg.sv ----
// Package of constants and carrier types for the serial shift latch sink driver
package sslsd_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int SSLSD_STAGES     = 8;   // Shift and latch stages
    localparam int SSLSD_FIFO_DEPTH = 8;   // Words in the frame buffer

    // ------------------------------------------------------------
    // Reset values and defaults
    // ------------------------------------------------------------
    localparam logic [7:0] SSLSD_SHIFT_RST = 8'h00;  // Shift register after reset
    localparam logic [7:0] SSLSD_LATCH_RST = 8'h00;  // Latches after reset
    localparam logic       SSLSD_BLANK_DFL = 1'b1;   // Blanking when undriven
    localparam logic       SSLSD_STRB_DFL  = 1'b0;   // Strobe when undriven
    localparam logic [2:0] SSLSD_CNT_RST   = 3'h0;   // Bit counter after reset

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    // Host pins, before and after synchronisation
    typedef struct packed {
        logic shift_clk;   // Shift clock level
        logic ser_in;      // Serial data level
        logic strobe;      // Latch strobe level
        logic blank;       // Blanking level
    } sslsd_pins_s;

    // Control state of the shift front end
    typedef enum logic [0:0] {
        SSLSD_IDLE,
        SSLSD_RUN
    } sslsd_state_e;

endpackage : sslsd_pkg

// ---- verilog/sslsd_fifo.sv ----
// Parameterised valid/ready FIFO holding completed shift words
`timescale 1ns/1ps
module sslsd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];      // Word storage
    logic [AW-1:0]    wr_ptr;           // Next write slot
    logic [AW-1:0]    rd_ptr;           // Next read slot
    logic [AW:0]      count;            // Words held
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));  // Honest full
    assign out_valid_o = (count != '0);              // Honest empty
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count arithmetic
    always_comb begin
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop  ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Pointer registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage write, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule // sslsd_fifo

// ---- verilog/sslsd_driver.sv ----
// Serial shift register, latch bank and blanked sink outputs
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module sslsd_driver
    import sslsd_pkg::*;
#(
    parameter int STAGES = SSLSD_STAGES,
    parameter int DEPTH  = SSLSD_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Host pins, asynchronous to clk_i
    input  wire logic              shift_clk_i,
    input  wire logic              ser_in_i,
    input  wire logic              strobe_i,
    input  wire logic              strobe_oe_i,
    input  wire logic              blank_i,
    input  wire logic              blank_oe_i,
    // Cascade output
    output logic                   ser_out_o,
    // Sink drive, high means sink on
    output logic [STAGES-1:0]      sink_lines_o,
    // Completed-word stream
    output logic                   word_valid_o,
    input  wire logic              word_ready_i,
    output logic [STAGES-1:0]      word_data_o,
    output logic                   word_drop_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sslsd_pins_s pins_raw;    // Pins with undriven defaults resolved
    sslsd_pins_s sync_a;      // First stage, read only by sync_b
    sslsd_pins_s sync_b;      // Second stage, safe to use
    logic        clk_prev;    // Previous synchronised shift clock
    logic        shift_rise;  // One-cycle rising edge of shift clock

    // Undriven strobe and blank pins fall back to their pull defaults
    always_comb begin
        pins_raw.shift_clk = shift_clk_i;
        pins_raw.ser_in    = ser_in_i;
        pins_raw.strobe    = strobe_oe_i ? strobe_i : SSLSD_STRB_DFL;
        pins_raw.blank     = blank_oe_i  ? blank_i  : SSLSD_BLANK_DFL;
    end

    // Two-flop synchroniser; reset holds outputs dark and latches closed
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync_a   <= '{shift_clk: 1'b0, ser_in: 1'b0, strobe: SSLSD_STRB_DFL, blank: SSLSD_BLANK_DFL};
            sync_b   <= '{shift_clk: 1'b0, ser_in: 1'b0, strobe: SSLSD_STRB_DFL, blank: SSLSD_BLANK_DFL};
            clk_prev <= 1'b0;
        end else begin
            sync_a   <= pins_raw;
            sync_b   <= sync_a;
            clk_prev <= sync_b.shift_clk;
        end
    end

    // Edge detection reads only the second stage
    assign shift_rise = sync_b.shift_clk && !clk_prev;

    // ------------------------------------------------------------
    // Shift register, latches and bit counter
    // ------------------------------------------------------------
    logic [STAGES-1:0] shift_reg;        // Stage 0 is the entry stage
    logic [STAGES-1:0] latch_q;          // Latch bank
    logic [2:0]        bit_cnt;          // Bits since last full word
    sslsd_state_e      state;            // Idle until the first clock
    logic [STAGES-1:0] next_shift_reg;
    logic [STAGES-1:0] next_latch_q;
    logic [2:0]        next_bit_cnt;
    sslsd_state_e      next_state;
    logic              word_done;        // Eighth bit just shifted in
    logic              fifo_ready;       // Buffer can take the word

    // Shift one step: new bit enters stage 0, others move up
    function automatic logic [STAGES-1:0] shift_step(input logic [STAGES-1:0] cur, input logic din);
        shift_step = {cur[STAGES-2:0], din};
    endfunction

    // Next-state logic of the shift front end
    always_comb begin
        next_shift_reg = shift_reg;
        next_bit_cnt   = bit_cnt;
        next_state     = state;
        word_done      = 1'b0;
        case (state)
            SSLSD_IDLE: begin
                if (shift_rise) begin
                    next_shift_reg = shift_step(shift_reg, sync_b.ser_in);
                    next_bit_cnt   = 3'h1;
                    next_state     = SSLSD_RUN;
                end
            end
            SSLSD_RUN: begin
                if (shift_rise) begin
                    next_shift_reg = shift_step(shift_reg, sync_b.ser_in);
                    next_bit_cnt   = bit_cnt + 3'h1;
                    word_done      = (bit_cnt == 3'h7);
                end
            end
            default: begin
                next_state = SSLSD_IDLE;
            end
        endcase
    end

    // Latches follow the register while strobed, else hold
    always_comb begin
        if (sync_b.strobe) begin
            next_latch_q = next_shift_reg;
        end else begin
            next_latch_q = latch_q;
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            shift_reg <= SSLSD_SHIFT_RST;
            latch_q   <= SSLSD_LATCH_RST;
            bit_cnt   <= SSLSD_CNT_RST;
            state     <= SSLSD_IDLE;
        end else begin
            shift_reg <= next_shift_reg;
            latch_q   <= next_latch_q;
            bit_cnt   <= next_bit_cnt;
            state     <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [STAGES-1:0] next_sink;
    logic [STAGES-1:0] sink_q;
    logic              drop_q;

    // Blanking gates drive only; latches are untouched
    always_comb begin
        if (sync_b.blank) begin
            next_sink = '0;
        end else begin
            next_sink = next_latch_q;
        end
    end

    // Output flops; dropped word flagged when the buffer is full
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sink_q <= '0;
            drop_q <= 1'b0;
        end else begin
            sink_q <= next_sink;
            drop_q <= word_done && !fifo_ready;
        end
    end

    assign sink_lines_o = sink_q;
    assign ser_out_o    = shift_reg[STAGES-1];
    assign word_drop_o  = drop_q;

    // ------------------------------------------------------------
    // Word buffer: each full eight-bit word is offered downstream
    // ------------------------------------------------------------
    // Shift timing belongs to the host, so a full buffer cannot stall it;
    // the word is dropped and reported instead.
    sslsd_fifo #(
        .WIDTH (STAGES),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (word_done),
        .in_ready_o  (fifo_ready),
        .in_data_i   (next_shift_reg),
        .out_valid_o (word_valid_o),
        .out_ready_i (word_ready_i),
        .out_data_o  (word_data_o)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_capture;
        @(posedge clk_i) disable iff (sys_rst_i)
        shift_rise |=> shift_reg[0] == $past(sync_b.ser_in);
    endproperty
    a_capture: assert property (p_capture) else $error("entry stage missed serial bit");

    property p_advance;
        @(posedge clk_i) disable iff (sys_rst_i)
        shift_rise |=> shift_reg[STAGES-1:1] == $past(shift_reg[STAGES-2:0]);
    endproperty
    a_advance: assert property (p_advance) else $error("stages did not advance");

    property p_hold_no_clk;
        @(posedge clk_i) disable iff (sys_rst_i)
        !shift_rise |=> $stable(shift_reg);
    endproperty
    a_hold_no_clk: assert property (p_hold_no_clk) else $error("shift without clock edge");

    property p_cascade;
        @(posedge clk_i) disable iff (sys_rst_i)
        ser_out_o == shift_reg[STAGES-1];
    endproperty
    a_cascade: assert property (p_cascade) else $error("cascade output wrong");

    property p_transparent;
        @(posedge clk_i) disable iff (sys_rst_i)
        sync_b.strobe |=> latch_q == shift_reg;
    endproperty
    a_transparent: assert property (p_transparent) else $error("latch not tracking");

    property p_latch_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        !sync_b.strobe |=> $stable(latch_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed while closed");

    property p_blank;
        @(posedge clk_i) disable iff (sys_rst_i)
        sync_b.blank |=> sink_lines_o == '0;
    endproperty
    a_blank: assert property (p_blank) else $error("sinks on while blanked");

    property p_follow;
        @(posedge clk_i) disable iff (sys_rst_i)
        !sync_b.blank |=> sink_lines_o == latch_q;
    endproperty
    a_follow: assert property (p_follow) else $error("sinks not following latches");

    property p_default_blank;
        @(posedge clk_i) disable iff (sys_rst_i)
        !blank_oe_i ##2 1'b1 |-> sync_b.blank;
    endproperty
    a_default_blank: assert property (p_default_blank) else $error("undriven blank not high");

endmodule // sslsd_driver

// ---- verif/sslsd_host_model.sv ----
// Host model that shifts frames and drives the strobe and blanking pins
`timescale 1ns/1ps
module sslsd_host_model (
    // Clock
    input  wire logic clk_i,
    // Host pins
    output logic      shift_clk_o,
    output logic      ser_in_o,
    output logic      strobe_o,
    output logic      strobe_oe_o,
    output logic      blank_o,
    output logic      blank_oe_o
);
    // ------------------------------------------------------------
    // Idle pin levels
    // ------------------------------------------------------------
    // Shift clock stands low outside frames; outputs start blanked
    initial begin
        shift_clk_o = 1'b0;
        ser_in_o    = 1'b0;
        strobe_o    = 1'b0;
        strobe_oe_o = 1'b1;
        blank_o     = 1'b1;
        blank_oe_o  = 1'b1;
    end

    // ------------------------------------------------------------
    // Frame shifting
    // ------------------------------------------------------------
    // Eight whole clocks per word, first bit is bit 7 of the word
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_i) ser_in_o <= w[i];
            // Four cycles high and five low, above the three the sampler needs
            repeat (4) @(posedge clk_i);
            shift_clk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            shift_clk_o <= 1'b0;
        end
        // Line no longer held: show the inverse so stale data cannot pass
        @(posedge clk_i) ser_in_o <= ~w[0];
    endtask

    // Strobe and blanking levels; an enable low leaves the pin undriven
    task automatic set_pins(input logic strb, input logic strb_oe, input logic blk, input logic blk_oe);
        @(posedge clk_i);
        strobe_o    <= strb;
        strobe_oe_o <= strb_oe;
        blank_o     <= blk;
        blank_oe_o  <= blk_oe;
    endtask
endmodule // sslsd_host_model

// ---- verif/tb.sv ----
// Self-checking testbench of the serial shift latch sink driver
`timescale 1ns/1ps
module tb;
    import sslsd_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_i        = 1'b0;  // 50 MHz system clock
    logic       sys_rst_i    = 1'b1;  // Held for five cycles
    logic       word_ready_i = 1'b0;  // Consumer stalls until asked
    logic       shift_clk_i, ser_in_i, strobe_i, strobe_oe_i, blank_i, blank_oe_i;
    logic       ser_out_o, word_valid_o, word_drop_o;
    logic [7:0] sink_lines_o, word_data_o;
    int         err_count    = 0;     // Mismatches seen
    int         total_checks = 0;     // Comparisons made
    int         drops        = 0;     // Drop pulses seen

    always #10 clk_i = ~clk_i;

    sslsd_host_model i_host (.clk_i(clk_i), .shift_clk_o(shift_clk_i), .ser_in_o(ser_in_i),
        .strobe_o(strobe_i), .strobe_oe_o(strobe_oe_i), .blank_o(blank_i), .blank_oe_o(blank_oe_i));

    sslsd_driver i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .shift_clk_i(shift_clk_i),
        .ser_in_i(ser_in_i), .strobe_i(strobe_i), .strobe_oe_i(strobe_oe_i), .blank_i(blank_i),
        .blank_oe_i(blank_oe_i), .ser_out_o(ser_out_o), .sink_lines_o(sink_lines_o),
        .word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .word_data_o(word_data_o),
        .word_drop_o(word_drop_o));

    // Drop is a one-cycle pulse; the falling edge sees it once, mid-pulse
    always @(negedge clk_i) if (word_drop_o === 1'b1) drops++;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Sample at the falling edge, where every output has settled
    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Wait for a word under a bound, compare it, then pop it
    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        while (word_valid_o !== 1'b1 && n < 50) begin
            @(negedge clk_i);
            n++;
        end
        chk({7'h00, word_valid_o}, 8'h01, "word valid");
        chk(word_data_o, exp, "word data");
        @(posedge clk_i) word_ready_i <= 1'b1;
        @(posedge clk_i) word_ready_i <= 1'b0;
        // Leave the popping edge behind so the next look sees the new head
        @(negedge clk_i);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_shift();
        i_host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
        i_host.send_word(8'ha5);
        settle(2);
        pop(8'ha5);
        chk({7'h00, ser_out_o}, 8'h01, "cascade bit");
        chk(sink_lines_o, 8'h00, "latches held at reset");
        $display("test shift done");
    endtask

    task automatic t_latch();
        i_host.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
        repeat (3) @(posedge clk_i);
        i_host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
        settle(6);
        chk(sink_lines_o, 8'ha5, "latched word on sinks");
        i_host.send_word(8'h3c);
        settle(2);
        pop(8'h3c);
        chk({7'h00, ser_out_o}, 8'h00, "cascade bit");
        chk(sink_lines_o, 8'ha5, "latches hold");
        $display("test latch done");
    endtask

    task automatic t_blank();
        i_host.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
        settle(6);
        chk(sink_lines_o, 8'h00, "blanked sinks");
        i_host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
        settle(6);
        chk(sink_lines_o, 8'ha5, "latches kept under blank");
        // Strobe driven high but not enabled must read low; blank reads high
        i_host.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
        settle(6);
        chk(sink_lines_o, 8'h00, "undriven blank");
        i_host.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
        settle(6);
        chk(sink_lines_o, 8'ha5, "undriven strobe holds");
        $display("test blank done");
    endtask

    task automatic t_bypass();
        // Latches transparent, so the host blanks while shifting
        i_host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        i_host.send_word(8'h81);
        settle(2);
        chk(sink_lines_o, 8'h00, "blanked during shifting");
        pop(8'h81);
        i_host.set_pins(1'b1, 1'b1, 1'b0, 1'b1);
        settle(6);
        chk(sink_lines_o, 8'h81, "transparent latches");
        i_host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
        $display("test bypass done");
    endtask

    task automatic t_fifo();
        // Consumer stalls: nine words into eight places, one is lost
        drops = 0;
        for (int i = 0; i < SSLSD_FIFO_DEPTH + 1; i++) i_host.send_word(8'h10 + 8'(i));
        settle(2);
        chk(drops[7:0], 8'h01, "drop pulses");
        for (int i = 0; i < SSLSD_FIFO_DEPTH; i++) pop(8'h10 + 8'(i));
        settle(2);
        chk({7'h00, word_valid_o}, 8'h00, "buffer empty");
        $display("test fifo done");
    endtask

    // ------------------------------------------------------------
    // Closing and sequencing
    // ------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // About 970 cycles of traffic; the limit leaves ample margin
    initial begin
        #100us;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_shift();
        t_latch();
        t_blank();
        t_bypass();
        t_fifo();
        results();
    end
endmodule // tb
